// ---- src/dual_mac_pkg.sv ----
`default_nettype none

package dual_mac_pkg;

   // Register byte offsets on the APB slave; each register is one aligned word.
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] ACC1_LO_OFFSET = 8'h08;
   localparam logic [7:0] ACC1_HI_OFFSET = 8'h0c;
   localparam logic [7:0] ACC2_LO_OFFSET = 8'h10;
   localparam logic [7:0] ACC2_HI_OFFSET = 8'h14;

   // Field positions in the control register.
   localparam int FRACTIONAL_MODE_BIT = 0;
   localparam int SATURATE_MULTIPLY_MODE_BIT = 1;
   localparam int SIGN_EXTENSION_MODE_BIT = 2;
   localparam int ROUNDING_MODE_BIT = 3;
   localparam int SATURATION_MODE_D_BIT = 4;
   localparam int WIDE_OVERFLOW_MODE_BIT = 5;
   localparam int CTRL_WIDTH = 6;

   // Field positions in the status register.
   localparam int FIRST_ACC_OVERFLOW_BIT = 0;
   localparam int SECOND_ACC_OVERFLOW_BIT = 1;

   // Reset values.
   localparam logic [5:0] CTRL_RESET = 6'h04;
   localparam logic [39:0] ACC_RESET = 40'h0000000000;

   // Arithmetic constants of the MAC lanes.
   localparam logic [16:0] MIN_OPERAND17 = 17'h18000;
   localparam logic [31:0] PRODUCT_SAT = 32'h7fffffff;
   localparam logic [40:0] ROUND_ADD = 41'h00000008000;
   localparam logic [15:0] ROUND_HALF = 16'h8000;
   localparam logic [39:0] SAT40_POS = 40'h7fffffffff;
   localparam logic [39:0] SAT40_NEG = 40'h8000000000;
   localparam logic [39:0] SAT32_POS = 40'h007fffffff;
   localparam logic [39:0] SAT32_NEG = 40'hff80000000;
   localparam int ACC_SHIFT = 16;

   // Instruction word pattern of the high/low dual-coefficient form.
   localparam logic [7:0] HILO_LEAD_BYTE = 8'hfd;
   localparam logic [5:0] HILO_THIRD_TOP = 6'h05;

   // Operation forms of the dual MAC instruction.
   typedef enum logic [2:0] {
      OP_PLAIN,
      OP_SHIFT_FIRST,
      OP_SHIFT_BOTH,
      OP_HILO,
      OP_HILO_SHIFT_FIRST,
      OP_HILO_SHIFT_BOTH
   } op_kind_t;

endpackage

`default_nettype wire

// ---- src/mac_lane.sv ----
`default_nettype none

module mac_lane (
   input wire logic [15:0] data_word,
   input wire logic [15:0] coef_word,
   input wire logic data_uns,
   input wire logic coef_uns,
   input wire logic sign_extension_mode,
   input wire logic fractional_mode,
   input wire logic saturate_multiply_mode,
   input wire logic rounding_mode,
   input wire logic round_en,
   input wire logic wide_overflow_mode,
   input wire logic saturation_mode_d,
   input wire logic shift_src,
   input wire logic lane_en,
   input wire logic [39:0] acc_in,
   output logic [39:0] acc_out,
   output logic overflow
);

   // Widens a memory word to the 17-bit multiplier input.
   function automatic logic [16:0] extend17(input logic [15:0] w, input logic uns,
                                            input logic sxm);
      if (uns) begin
         return {1'b0, w};
      end
      return {sxm & w[15], w};
   endfunction

   logic [16:0] data17;
   logic [16:0] coef17;
   logic signed [33:0] prod_full;
   logic [31:0] prod32;
   logic [31:0] prod_final;
   logic [39:0] src;
   logic [40:0] sum;
   logic [40:0] rsum;
   logic ov;
   logic [39:0] result;

   ////////////////////////////////////////////////////////////////////////////
   // Multiplier with fractional shift and product saturation.
   always_comb begin
      data17 = extend17(data_word, data_uns, sign_extension_mode);
      coef17 = extend17(coef_word, coef_uns, sign_extension_mode);
      prod_full = $signed(data17) * $signed(coef17);
      prod32 = prod_full[31:0];
      if (fractional_mode) begin
         prod32 = {prod32[30:0], 1'b0};
      end
      // Only -1 times -1 in fractional form leaves the 32-bit range.
      prod_final = prod32;
      if (saturate_multiply_mode && fractional_mode && data17 == dual_mac_pkg::MIN_OPERAND17 &&
          coef17 == dual_mac_pkg::MIN_OPERAND17) begin
         prod_final = dual_mac_pkg::PRODUCT_SAT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Accumulation, rounding, overflow detection and saturation.
   always_comb begin
      src = acc_in;
      if (shift_src) begin
         src = {{dual_mac_pkg::ACC_SHIFT{acc_in[39]}}, acc_in[39:16]};
      end
      sum = {src[39], src} + {{9{prod_final[31]}}, prod_final};
      rsum = sum;
      if (round_en) begin
         rsum = sum + dual_mac_pkg::ROUND_ADD;
         // Unbiased rounding breaks an exact tie towards an even upper part.
         if (rounding_mode && sum[15:0] == dual_mac_pkg::ROUND_HALF) begin
            rsum[16] = 1'b0;
         end
         rsum[15:0] = 16'h0000;
      end
      if (wide_overflow_mode) begin
         ov = rsum[40] != rsum[39];
      end else begin
         ov = !((&rsum[40:31]) || !(|rsum[40:31]));
      end
      result = rsum[39:0];
      if (ov && saturation_mode_d) begin
         if (wide_overflow_mode) begin
            result = rsum[40] ? dual_mac_pkg::SAT40_NEG : dual_mac_pkg::SAT40_POS;
         end else begin
            result = rsum[40] ? dual_mac_pkg::SAT32_NEG : dual_mac_pkg::SAT32_POS;
         end
      end
      acc_out = lane_en ? result : acc_in;
      overflow = lane_en & ov;
   end

endmodule // mac_lane

`default_nettype wire

// ---- src/dual_mac_coefficient_datapath.sv ----
// Design decisions made here: register access over APB and the placing of the registers.
`default_nettype none

module dual_mac_coefficient_datapath #(
   parameter int ADDR_WIDTH = 23
) (
   input wire logic clock,
   input wire logic sys_rst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Instruction issue from the core.
   input wire logic op_valid,
   input wire dual_mac_pkg::op_kind_t op_kind,
   input wire logic word_valid,
   input wire logic [31:0] instr_word,
   input wire logic uns_x,
   input wire logic uns_y,
   input wire logic uns_c,
   input wire logic round_qualifier,
   input wire logic wide_keyword,
   input wire logic modify_only_x,
   input wire logic modify_only_y,
   input wire logic modify_only_c,
   // Operand buses.
   input wire logic [15:0] xmem_data,
   input wire logic [15:0] ymem_data,
   input wire logic [15:0] coefficient_bus_data,
   input wire logic [15:0] d_read_bus_data,
   input wire logic [15:0] b_read_bus_data,
   input wire logic [15:0] b2_read_bus_data,
   input wire logic [ADDR_WIDTH-1:0] effective_address,
   // Address side and results.
   output logic [ADDR_WIDTH-1:0] coef_high_addr,
   output logic [ADDR_WIDTH-1:0] coef_low_addr,
   output logic coefficient_bus_fetch,
   output logic hilo_fetch,
   output logic pointer_update_x,
   output logic pointer_update_y,
   output logic pointer_update_c,
   output logic [39:0] first_accumulator,
   output logic [39:0] second_accumulator,
   output logic first_acc_overflow_flag,
   output logic second_acc_overflow_flag
);

   if (ADDR_WIDTH < 2 || ADDR_WIDTH > 32) begin : g_bad_width
      $error("ADDR_WIDTH must lie between 2 and 32");
   end

   typedef struct packed {
      logic [dual_mac_pkg::CTRL_WIDTH-1:0] ctrl;
      logic ov1;
      logic ov2;
      logic [39:0] acc1;
      logic [39:0] acc2;
      logic [31:0] rdata;
      logic slverr;
   } state_t;

   state_t st_q;
   state_t st_d;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers.

   // Recognises the high/low dual-coefficient form in a full instruction word.
   function automatic logic is_hilo_word(input logic [31:0] w);
      return w[31:24] == dual_mac_pkg::HILO_LEAD_BYTE &&
             w[15:10] == dual_mac_pkg::HILO_THIRD_TOP;
   endfunction

   // True for any form that fetches a long coefficient pair.
   function automatic logic is_hilo(input dual_mac_pkg::op_kind_t k);
      return k == dual_mac_pkg::OP_HILO || k == dual_mac_pkg::OP_HILO_SHIFT_FIRST ||
             k == dual_mac_pkg::OP_HILO_SHIFT_BOTH;
   endfunction

   // Address decode shared by the write strobe and the error answer.
   function automatic logic is_mapped(input logic [7:0] a);
      return a == dual_mac_pkg::CTRL_OFFSET || a == dual_mac_pkg::STATUS_OFFSET ||
             a == dual_mac_pkg::ACC1_LO_OFFSET || a == dual_mac_pkg::ACC1_HI_OFFSET ||
             a == dual_mac_pkg::ACC2_LO_OFFSET || a == dual_mac_pkg::ACC2_HI_OFFSET;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Operation form and lane steering.

   dual_mac_pkg::op_kind_t kind;
   logic hilo;
   logic shift_first;
   logic shift_second;
   logic lane1_en;
   logic lane2_en;
   logic wide_eff;
   logic [15:0] lane1_data;
   logic [15:0] lane1_coef;
   logic [15:0] lane2_data;
   logic [15:0] lane2_coef;
   logic lane1_data_uns;
   logic lane2_data_uns;
   logic [39:0] lane1_acc;
   logic [39:0] lane2_acc;
   logic lane1_ov;
   logic lane2_ov;

   // A recognised instruction word overrides the decoded form from the core.
   always_comb begin
      kind = op_kind;
      if (word_valid && is_hilo_word(instr_word)) begin
         kind = dual_mac_pkg::OP_HILO;
      end
      hilo = is_hilo(kind);
      shift_first = 1'b0;
      shift_second = 1'b0;
      unique case (kind)
         dual_mac_pkg::OP_PLAIN, dual_mac_pkg::OP_HILO: begin
            shift_first = 1'b0;
         end
         dual_mac_pkg::OP_SHIFT_FIRST, dual_mac_pkg::OP_HILO_SHIFT_FIRST: begin
            shift_first = 1'b1;
         end
         dual_mac_pkg::OP_SHIFT_BOTH, dual_mac_pkg::OP_HILO_SHIFT_BOTH: begin
            shift_first = 1'b1;
            shift_second = 1'b1;
         end
         default: begin
            shift_first = 1'b0;
         end
      endcase
   end

   // An X pointer-only flow, or a Y one outside the high/low form, takes its lane out of the
   // multiply, and a coefficient pointer-only flow removes the coefficient that both lanes would share.
   always_comb begin
      lane1_en = op_valid && !modify_only_c && !modify_only_x;
      lane2_en = op_valid && !modify_only_c && !(modify_only_y && !hilo);
      wide_eff = st_q.ctrl[dual_mac_pkg::WIDE_OVERFLOW_MODE_BIT] | wide_keyword;
      if (hilo) begin
         lane1_data = d_read_bus_data;
         lane2_data = d_read_bus_data;
         lane1_coef = b_read_bus_data;
         lane2_coef = b2_read_bus_data;
         lane1_data_uns = uns_x;
         lane2_data_uns = uns_x;
      end else begin
         lane1_data = xmem_data;
         lane2_data = ymem_data;
         lane1_coef = coefficient_bus_data;
         lane2_coef = coefficient_bus_data;
         lane1_data_uns = uns_x;
         lane2_data_uns = uns_y;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The two MAC units; both settle in the same cycle as the issue.

   mac_lane u_mac_unit_one (
      .data_word(lane1_data),
      .coef_word(lane1_coef),
      .data_uns(lane1_data_uns),
      .coef_uns(uns_c),
      .sign_extension_mode(st_q.ctrl[dual_mac_pkg::SIGN_EXTENSION_MODE_BIT]),
      .fractional_mode(st_q.ctrl[dual_mac_pkg::FRACTIONAL_MODE_BIT]),
      .saturate_multiply_mode(st_q.ctrl[dual_mac_pkg::SATURATE_MULTIPLY_MODE_BIT]),
      .rounding_mode(st_q.ctrl[dual_mac_pkg::ROUNDING_MODE_BIT]),
      .round_en(round_qualifier),
      .wide_overflow_mode(wide_eff),
      .saturation_mode_d(st_q.ctrl[dual_mac_pkg::SATURATION_MODE_D_BIT]),
      .shift_src(shift_first),
      .lane_en(lane1_en),
      .acc_in(st_q.acc1),
      .acc_out(lane1_acc),
      .overflow(lane1_ov)
   );

   mac_lane u_mac_unit_two (
      .data_word(lane2_data),
      .coef_word(lane2_coef),
      .data_uns(lane2_data_uns),
      .coef_uns(uns_c),
      .sign_extension_mode(st_q.ctrl[dual_mac_pkg::SIGN_EXTENSION_MODE_BIT]),
      .fractional_mode(st_q.ctrl[dual_mac_pkg::FRACTIONAL_MODE_BIT]),
      .saturate_multiply_mode(st_q.ctrl[dual_mac_pkg::SATURATE_MULTIPLY_MODE_BIT]),
      .rounding_mode(st_q.ctrl[dual_mac_pkg::ROUNDING_MODE_BIT]),
      .round_en(round_qualifier),
      .wide_overflow_mode(wide_eff),
      .saturation_mode_d(st_q.ctrl[dual_mac_pkg::SATURATION_MODE_D_BIT]),
      .shift_src(shift_second),
      .lane_en(lane2_en),
      .acc_in(st_q.acc2),
      .acc_out(lane2_acc),
      .overflow(lane2_ov)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Coefficient addressing and pointer strobes toward the address generators.

   // The partner word of an aligned long coefficient sits at the other parity.
   always_comb begin
      coef_high_addr = effective_address;
      if (effective_address[0]) begin
         coef_low_addr = effective_address - ADDR_WIDTH'(1);
      end else begin
         coef_low_addr = effective_address + ADDR_WIDTH'(1);
      end
      coefficient_bus_fetch = op_valid && !hilo && !modify_only_c;
      hilo_fetch = op_valid && hilo && !modify_only_c;
      pointer_update_x = op_valid;
      pointer_update_y = op_valid && !hilo;
      pointer_update_c = op_valid;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state: accumulators, sticky flags and the APB slave.

   logic setup;
   logic wr;
   logic [31:0] rd_word;

   always_comb begin
      setup = psel && !penable;
      wr = psel && penable && pwrite && is_mapped(paddr);
      st_d = st_q;
      // Software loads go first so that a same-cycle issue overrides them.
      if (wr) begin
         unique case (paddr)
            dual_mac_pkg::CTRL_OFFSET: begin
               st_d.ctrl = pwdata[dual_mac_pkg::CTRL_WIDTH-1:0];
            end
            dual_mac_pkg::STATUS_OFFSET: begin
               st_d.ov1 = st_q.ov1 & !pwdata[dual_mac_pkg::FIRST_ACC_OVERFLOW_BIT];
               st_d.ov2 = st_q.ov2 & !pwdata[dual_mac_pkg::SECOND_ACC_OVERFLOW_BIT];
            end
            dual_mac_pkg::ACC1_LO_OFFSET: begin
               st_d.acc1[31:0] = pwdata;
            end
            dual_mac_pkg::ACC1_HI_OFFSET: begin
               st_d.acc1[39:32] = pwdata[7:0];
            end
            dual_mac_pkg::ACC2_LO_OFFSET: begin
               st_d.acc2[31:0] = pwdata;
            end
            dual_mac_pkg::ACC2_HI_OFFSET: begin
               st_d.acc2[39:32] = pwdata[7:0];
            end
            default: begin
               st_d.slverr = st_q.slverr;
            end
         endcase
      end
      // Both lanes commit together at the edge after issue, every cycle if
      // needed, so a repeated instruction streams one result pair per cycle.
      if (op_valid) begin
         st_d.acc1 = lane1_acc;
         st_d.acc2 = lane2_acc;
      end
      // An overflow in the clearing cycle still sets its flag.
      if (lane1_ov) begin
         st_d.ov1 = 1'b1;
      end
      if (lane2_ov) begin
         st_d.ov2 = 1'b1;
      end
      // Read data and error are latched in setup and held through access.
      rd_word = 32'h00000000;
      unique case (paddr)
         dual_mac_pkg::CTRL_OFFSET: begin
            rd_word[dual_mac_pkg::CTRL_WIDTH-1:0] = st_q.ctrl;
         end
         dual_mac_pkg::STATUS_OFFSET: begin
            rd_word[dual_mac_pkg::FIRST_ACC_OVERFLOW_BIT] = st_q.ov1;
            rd_word[dual_mac_pkg::SECOND_ACC_OVERFLOW_BIT] = st_q.ov2;
         end
         dual_mac_pkg::ACC1_LO_OFFSET: begin
            rd_word = st_q.acc1[31:0];
         end
         dual_mac_pkg::ACC1_HI_OFFSET: begin
            rd_word[7:0] = st_q.acc1[39:32];
         end
         dual_mac_pkg::ACC2_LO_OFFSET: begin
            rd_word = st_q.acc2[31:0];
         end
         dual_mac_pkg::ACC2_HI_OFFSET: begin
            rd_word[7:0] = st_q.acc2[39:32];
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
      if (setup) begin
         st_d.rdata = pwrite ? 32'h00000000 : rd_word;
         st_d.slverr = !is_mapped(paddr);
      end
   end

   // Single register stage for all state.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_q <= '{ctrl: dual_mac_pkg::CTRL_RESET, ov1: 1'b0, ov2: 1'b0,
                   acc1: dual_mac_pkg::ACC_RESET, acc2: dual_mac_pkg::ACC_RESET,
                   rdata: 32'h00000000, slverr: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // The slave never inserts wait states; data is ready from the setup edge.
   assign pready = 1'b1;
   assign prdata = st_q.rdata;
   assign pslverr = st_q.slverr;
   assign first_accumulator = st_q.acc1;
   assign second_accumulator = st_q.acc2;
   assign first_acc_overflow_flag = st_q.ov1;
   assign second_acc_overflow_flag = st_q.ov2;

endmodule // dual_mac_coefficient_datapath

`default_nettype wire

// ---- tb/coef_mem_model.sv ----
`default_nettype none

// Coefficient memory behind the b and b2 read buses.
module coef_mem_model #(
   parameter int AW = 23
) (
   input wire logic clock,
   input wire logic fetch,
   input wire logic [AW-1:0] hi_addr,
   input wire logic [AW-1:0] lo_addr,
   output logic [15:0] b_data,
   output logic [15:0] b2_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] lb_q, lb2_q;
   // Coefficients all sit in internal memory, so every fetch is answered.
   // An idle bus shows the inverse of what it showed the cycle before, so a stale value never holds for two cycles.
   always_comb begin
      b_data = fetch ? lo_addr[15:0] ^ 16'h6c31 : ~lb_q;
      b2_data = fetch ? hi_addr[15:0] ^ 16'h6c31 : ~lb2_q;
   end
   // Remember what each bus showed last.
   always_ff @(posedge clock) begin
      lb_q <= b_data;
      lb2_q <= b2_data;
   end
endmodule // coef_mem_model

`default_nettype wire

// ---- tb/dual_mac_sva.sv ----
`default_nettype none

module dual_mac_sva #(
   parameter int ADDR_WIDTH = 23
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic op_valid,
   input wire dual_mac_pkg::op_kind_t op_kind,
   input wire logic word_valid,
   input wire logic [31:0] instr_word,
   input wire logic modify_only_c,
   input wire logic [ADDR_WIDTH-1:0] effective_address,
   input wire logic [ADDR_WIDTH-1:0] coef_high_addr,
   input wire logic [ADDR_WIDTH-1:0] coef_low_addr,
   input wire logic coefficient_bus_fetch,
   input wire logic hilo_fetch,
   input wire logic pointer_update_x,
   input wire logic pointer_update_c,
   input wire logic [39:0] first_accumulator,
   input wire logic [39:0] second_accumulator,
   input wire logic first_acc_overflow_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic hl, wr;
   // A matching instruction word forces the high/low form whatever the kind says.
   assign hl = op_kind >= dual_mac_pkg::OP_HILO
      || (word_valid && instr_word[31:24] == 8'hfd && instr_word[15:10] == 6'h05);
   assign wr = psel && penable && pwrite;
   a_high_addr: assert property (coef_high_addr == effective_address)
      else $error("high coefficient address wrong");
   a_low_addr: assert property (coef_low_addr == (effective_address[0] ?
      effective_address - 1'b1 : effective_address + 1'b1)) else $error("low address wrong");
   a_hilo_fetch: assert property (hilo_fetch == (op_valid && hl && !modify_only_c))
      else $error("hilo fetch wrong");
   a_coef_fetch: assert property (coefficient_bus_fetch == (op_valid && !hl && !modify_only_c))
      else $error("coefficient fetch wrong");
   a_ptr_update: assert property (pointer_update_x == op_valid && pointer_update_c == op_valid)
      else $error("pointer update wrong");
   a_acc_hold: assert property (!op_valid && !wr |=> $stable(first_accumulator)
      && $stable(second_accumulator)) else $error("accumulator moved while idle");
   a_skip_lanes: assert property (op_valid && modify_only_c && !wr |=>
      $stable(first_accumulator) && $stable(second_accumulator)) else $error("lane not skipped");
   a_flag_sticky: assert property (first_acc_overflow_flag
      && !(wr && paddr == 8'h04 && pwdata[0]) |=> first_acc_overflow_flag) else $error("flag lost");
   a_flag_cause: assert property ($rose(first_acc_overflow_flag) |-> $past(op_valid))
      else $error("flag set without an operation");
   c_hilo: cover property (hilo_fetch);
   c_repeat: cover property (op_valid [*3]);
   c_ovf: cover property ($rose(first_acc_overflow_flag));
endmodule // dual_mac_sva

`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int AW = 23;
   logic clock = 1'b0, sys_rst = 1'b1, psel = '0, penable = '0, pwrite = '0, pready, pslverr, er;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, instr_word = '0, rd;
   logic op_valid = '0, word_valid = '0, uns_x = '0, uns_y = '0, uns_c = '0;
   logic round_qualifier = '0, wide_keyword = '0, modify_only_x = '0, modify_only_y = '0;
   logic modify_only_c = '0, coefficient_bus_fetch, hilo_fetch;
   logic pointer_update_x, pointer_update_y, pointer_update_c;
   logic first_acc_overflow_flag, second_acc_overflow_flag;
   logic ux, uy, uc, rn, wd, mx, my, mc, hl, s1, s2, f1, f2;
   dual_mac_pkg::op_kind_t op_kind = dual_mac_pkg::OP_PLAIN;
   logic [15:0] xmem_data = '0, ymem_data = '0, coefficient_bus_data = '0, d_read_bus_data = '0;
   logic [15:0] b_read_bus_data, b2_read_bus_data, xd, yd, cd;
   logic [AW-1:0] effective_address = '0, coef_high_addr, coef_low_addr, ea, la;
   logic [39:0] first_accumulator, second_accumulator, a1, a2;
   logic [40:0] r;
   logic [5:0] c;
   int err_total = 0, n_tests = 0, cyc = 0, k;

   dual_mac_coefficient_datapath #(.ADDR_WIDTH(AW)) dut (.clock, .sys_rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .op_valid, .op_kind, .word_valid,
      .instr_word, .uns_x, .uns_y, .uns_c, .round_qualifier, .wide_keyword, .modify_only_x,
      .modify_only_y, .modify_only_c, .xmem_data, .ymem_data, .coefficient_bus_data,
      .d_read_bus_data, .b_read_bus_data, .b2_read_bus_data, .effective_address, .coef_high_addr,
      .coef_low_addr, .coefficient_bus_fetch, .hilo_fetch, .pointer_update_x, .pointer_update_y,
      .pointer_update_c, .first_accumulator, .second_accumulator, .first_acc_overflow_flag,
      .second_acc_overflow_flag);
   coef_mem_model #(.AW(AW)) mem (.clock, .fetch(hilo_fetch), .hi_addr(coef_high_addr),
      .lo_addr(coef_low_addr), .b_data(b_read_bus_data), .b2_data(b2_read_bus_data));

   ////////////////////////////////////////////////////////////////
   // Free running clock.
   always #25 clock = ~clock;
   // A hung handshake must still reach the verdict.
   always @(posedge clock) begin
      cyc++;
      if (cyc > 3000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task end_of_test();
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      op_valid <= 1'b0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reference lane; returns the overflow bit above the 40-bit result.
   function automatic logic [40:0] lane(input logic [39:0] acc, input logic [15:0] a,
      input logic [15:0] b, input logic ua, input logic ub, input logic sh);
      logic [16:0] xa, xb;
      logic signed [33:0] p;
      logic [31:0] q;
      logic [40:0] s;
      logic [39:0] t;
      logic w, o;
      xa = {!ua && c[2] && a[15], a};
      xb = {!ub && c[2] && b[15], b};
      p = $signed(xa) * $signed(xb);
      q = c[0] ? {p[30:0], 1'b0} : p[31:0];
      if (c[1] && c[0] && xa == 17'h18000 && xb == 17'h18000) q = 32'h7fffffff;
      t = sh ? {{16{acc[39]}}, acc[39:16]} : acc;
      s = {t[39], t} + {{9{q[31]}}, q};
      if (rn) begin
         s = s + 41'h8000;
         if (c[3] && s[15:0] == 16'h0) s[16] = 1'b0;
         s[15:0] = 16'h0;
      end
      w = wd || c[5];
      o = w ? s[40] != s[39] : !(&s[40:31] || !(|s[40:31]));
      if (o && c[4]) s[39:0] = w ? (s[40] ? 40'h8000000000 : 40'h7fffffffff)
         : (s[40] ? 40'hff80000000 : 40'h007fffffff);
      return {o, s[39:0]};
   endfunction

   ////////////////////////////////////////////////////////////////
   // Reset values, an unmapped place, preload, then a run of operations.
   initial begin
      f1 = 1'b0;
      f2 = 1'b0;
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      for (int j = 0; j < 6; j++) begin
         apb(1'b0, 8'(j * 4), '0);
         chk({er, rd}, j == 0 ? 33'h4 : 33'h0);
      end
      apb(1'b1, 8'h20, 32'h5);
      chk({er, rd}, 33'h100000000);
      a1 = 40'h7fffff0000;
      a2 = 40'hff80001234;
      apb(1'b1, dual_mac_pkg::ACC1_LO_OFFSET, a1[31:0]);
      apb(1'b1, dual_mac_pkg::ACC1_HI_OFFSET, 32'(a1[39:32]));
      apb(1'b1, dual_mac_pkg::ACC2_LO_OFFSET, a2[31:0]);
      apb(1'b1, dual_mac_pkg::ACC2_HI_OFFSET, 32'(a2[39:32]));
      apb(1'b0, dual_mac_pkg::ACC1_HI_OFFSET, '0);
      chk(rd, 32'h7f);
      for (int i = 0; i < 64; i++) begin
         if (i % 4 == 0) begin
            c = 6'(i / 4 * 5);
            apb(1'b1, dual_mac_pkg::CTRL_OFFSET, 32'(c));
         end
         if (i % 16 == 15) begin
            apb(1'b0, dual_mac_pkg::STATUS_OFFSET, '0);
            chk(rd, {f2, f1});
            apb(1'b1, dual_mac_pkg::STATUS_OFFSET, 32'h3);
            f1 = 1'b0;
            f2 = 1'b0;
         end
         k = (i % 9 == 4) ? 3 : i % 6;
         hl = k >= 3;
         s1 = k == 1 || k == 2 || k == 4 || k == 5;
         s2 = k == 2 || k == 5;
         {ux, uy, uc, rn, wd} = {i[2] ^ i[3], i[3], i[4], i[1], i % 5 == 1};
         {mx, my, mc} = {i % 7 == 3, i % 5 == 2, i % 11 == 5};
         xd = i[1:0] == 2'h0 ? 16'h8000 : 16'(i * 16'h0b4d);
         yd = 16'(i * 16'h3c17 + 16'h9000);
         cd = i[1:0] == 2'h0 ? 16'h8000 : 16'(i * 16'h02f1);
         ea = AW'(i * 16'h02b5);
         la = ea[0] ? ea - 1'b1 : ea + 1'b1;
         @(posedge clock);
         op_valid <= 1'b1;
         op_kind <= dual_mac_pkg::op_kind_t'(i % 6);
         word_valid <= i % 9 == 4;
         instr_word <= {8'hfd, 8'h00, 6'h05, 2'(i), 8'h00};
         {uns_x, uns_y, uns_c, round_qualifier, wide_keyword} <= {ux, uy, uc, rn, wd};
         {modify_only_x, modify_only_y, modify_only_c} <= {mx, my, mc};
         xmem_data <= xd;
         ymem_data <= yd;
         coefficient_bus_data <= cd;
         d_read_bus_data <= xd;
         effective_address <= ea;
         @(negedge clock);
         chk(first_accumulator, a1);
         chk(second_accumulator, a2);
         chk({second_acc_overflow_flag, first_acc_overflow_flag}, {f2, f1});
         chk(coef_low_addr, la);
         chk(coef_high_addr, ea);
         chk({coefficient_bus_fetch, hilo_fetch, pointer_update_x, pointer_update_y,
            pointer_update_c}, {!hl && !mc, hl && !mc, 1'b1, !hl, 1'b1});
         if (!mx && !mc) begin
            r = lane(a1, xd, hl ? la[15:0] ^ 16'h6c31 : cd, ux, uc, s1);
            a1 = r[39:0];
            f1 |= r[40];
         end
         if (!mc && (hl || !my)) begin
            r = lane(a2, hl ? xd : yd, hl ? ea[15:0] ^ 16'h6c31 : cd, hl ? ux : uy, uc, s2);
            a2 = r[39:0];
            f2 |= r[40];
         end
      end
      @(posedge clock);
      op_valid <= 1'b0;
      @(negedge clock);
      chk(first_accumulator, a1);
      chk(second_accumulator, a2);
      end_of_test();
   end
endmodule // tb

bind dual_mac_coefficient_datapath dual_mac_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.clock,
   .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .op_valid, .op_kind, .word_valid,
   .instr_word, .modify_only_c, .effective_address, .coef_high_addr, .coef_low_addr,
   .coefficient_bus_fetch, .hilo_fetch, .pointer_update_x, .pointer_update_c,
   .first_accumulator, .second_accumulator, .first_acc_overflow_flag);

`default_nettype wire
